// ===== include/tdc_seq_map.svh
`ifndef TDC_SEQ_MAP_SVH
`define TDC_SEQ_MAP_SVH
`define CLK_MHZ       200
`define REF_MHZ       4
`define REF_DIV       (`CLK_MHZ / `REF_MHZ)
`define T_CHARGE_US   16
`define CHARGE_CYC    (`T_CHARGE_US * `CLK_MHZ)
`define T_SHORT_US    8
`define SHORT_CYC     (`T_SHORT_US * `CLK_MHZ)
`define T_OPEN_US     2
`define OPEN_CYC      (`T_OPEN_US * `CLK_MHZ)
`define T_PORT_CYC_US 128
`define T_CAL_TO_US   40
`define OP_TEMP       8'h03
`define OP_CAL        8'h0E
`define RD_BASE       8'hE0
`define RD_LAST       8'hE9
`define RD_STAT       8'hFE
`define OP_BITS       4'h8
`define ST_W          3
`define ST_TEMP       0
`define ST_CAL        1
`define ST_TO         2
`define SEL_NONE      3'h0
`define SEL_EMUL      3'h5
`define RES_SHORT     16'h0000
`define RES_BAD       16'hFFFF
`define SYNC_RST      5'h10
`endif

// ===== include/tdc_seq_pkg.sv
package tdc_seq_pkg;
  typedef enum logic [2:0] {T_IDLE, T_CHARGE, T_MEAS, T_WAIT, T_DONE}
    temp_state_t;
  typedef enum logic [1:0] {C_IDLE, C_SYNC, C_RUN} cal_state_t;
endpackage

// ===== verilog/tdc_temp_cal_irq_sequencer.sv
`timescale 1ns/1ps
`include "tdc_seq_map.svh"
module tdc_temp_cal_irq_sequencer #(
  parameter int unsigned PORT_CYC_BASE = `T_PORT_CYC_US * `CLK_MHZ,
  parameter int unsigned CAL_TO_BASE   = `T_CAL_TO_US * `CLK_MHZ
) (
  input  wire logic            clk_sys_i,
  input  wire logic            reset_i,
  input  wire logic            ce_n_i,
  input  wire logic            sck_i,
  input  wire logic            din_i,
  output logic                 dout_o,
  input  wire logic            clk_32k_i,
  input  wire logic            cap_above_i,
  output logic                 cap_charge_pin_o,
  output logic [2:0]           port_route_o,
  input  wire logic [1:0]      port_select_i,
  input  wire logic [2:0]      dummy_cycle_count_i,
  input  wire logic [1:0]      port_cycle_interval_i,
  input  wire logic [3:0]      cal_period_i,
  input  wire logic [2:0]      measure_timeout_sel_i,
  input  wire logic            int_enable_i,
  output logic [`ST_W-1:0]     int_status_o,
  output logic                 int_n_o
);
  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == `RD_STAT) || (op >= `RD_BASE && op <= `RD_LAST);
  endfunction

  // Cycles of clk_sys scaled to 4 MHz periods, 16 fraction bits
  function automatic logic [30:0] to_tdc(input logic [31:0] cyc,
                                         input logic [3:0]  n);
    logic [47:0] num;
    num = {cyc, 16'h0000};
    to_tdc = 31'(num / (48'(`REF_DIV) * 48'(n)));
  endfunction

  function automatic logic [2:0] port_of(input logic [1:0] sel,
                                         input logic [1:0] k);
    case (sel)
      2'h0:    port_of = k[0] ? 3'h3 : 3'h1;
      2'h1:    port_of = k[0] ? 3'h4 : 3'h2;
      2'h2:    port_of = k[0] ? 3'h2 : 3'h1;
      default: port_of = 3'(k) + 3'h1;
    endcase
  endfunction

  // Pin synchronisers; first stage feeds only the second
  logic [4:0] sync1_reg, sync2_reg, prev_reg;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sync1_reg <= `SYNC_RST;
      sync2_reg <= `SYNC_RST;
      prev_reg  <= `SYNC_RST;
    end else begin
      sync1_reg <= {ce_n_i, sck_i, din_i, clk_32k_i, cap_above_i};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire ce_n      = sync2_reg[4];
  wire sck       = sync2_reg[3];
  wire din       = sync2_reg[2];
  wire cap_above = sync2_reg[0];
  wire ce_fall   = prev_reg[4] & ~ce_n;
  wire ce_rise   = ~prev_reg[4] & ce_n;
  wire sck_fall  = ~ce_n & prev_reg[3] & ~sck;
  wire sck_rise  = ~ce_n & ~prev_reg[3] & sck;
  wire c32_rise  = ~prev_reg[1] & sync2_reg[1];

  // Serial port
  logic [3:0]  bitcnt_reg, txcnt_reg;
  logic [7:0]  shin_reg, op_reg, rd_addr_reg;
  logic        rd_mode_reg;
  logic [15:0] tx_reg;
  logic [`ST_W-1:0] stat_reg;
  logic [15:0] res_int [0:3];
  logic [15:0] res_frac [0:3];
  logic [15:0] cal_int_reg, cal_frac_reg;

  wire [7:0]  op_now    = {shin_reg[6:0], din};
  wire        op_done   = sck_fall & (bitcnt_reg == `OP_BITS - 4'h1);
  wire        word_done = sck_rise & rd_mode_reg & (txcnt_reg == 4'hF);
  wire        load      = (op_done & is_read(op_now)) | word_done;
  wire [7:0]  ld_addr   = op_done ? op_now : rd_addr_reg + 8'h01;
  wire [7:0]  ridx      = ld_addr - `RD_BASE;
  wire [15:0] rd_word   =
    (ld_addr == `RD_STAT) ? 16'(stat_reg) :
    !is_read(ld_addr)     ? 16'h0000 :
    ridx[3] ? (ridx[0] ? cal_frac_reg : cal_int_reg) :
              (ridx[0] ? res_frac[ridx[2:1]] : res_int[ridx[2:1]]);
  wire        opc_ok    = ce_rise & (bitcnt_reg == `OP_BITS);
  wire        start_temp = opc_ok & (op_reg == `OP_TEMP);
  wire        start_cal  = opc_ok & (op_reg == `OP_CAL);

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bitcnt_reg  <= 4'h0;
      txcnt_reg   <= 4'h0;
      shin_reg    <= 8'h00;
      op_reg      <= 8'h00;
      rd_addr_reg <= 8'h00;
      rd_mode_reg <= 1'b0;
      tx_reg      <= 16'h0000;
      dout_o      <= 1'b0;
    end else begin
      if (ce_fall) begin
        bitcnt_reg  <= 4'h0;
        txcnt_reg   <= 4'h0;
        rd_mode_reg <= 1'b0;
      end else if (sck_fall && bitcnt_reg < `OP_BITS) begin
        bitcnt_reg <= bitcnt_reg + 4'h1;
        shin_reg   <= op_now;
      end else if (sck_rise && rd_mode_reg) begin
        txcnt_reg <= txcnt_reg + 4'h1;
      end
      if (op_done) begin
        op_reg      <= op_now;
        rd_mode_reg <= is_read(op_now);
      end
      if (load) begin
        rd_addr_reg <= ld_addr;
        tx_reg      <= rd_word;
      end else if (sck_rise && rd_mode_reg) begin
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
      if (ce_n)
        dout_o <= 1'b0;
      else if (sck_rise && rd_mode_reg)
        dout_o <= tx_reg[15];
    end
  end

  // Temperature sequence
  tdc_seq_pkg::temp_state_t tst_reg;
  logic [4:0]  stp_reg;
  logic [31:0] tcnt_reg, mcnt_reg;
  logic        err_reg, temp_set_reg, to_t_reg;
  logic [15:0] tmp_int [0:3];
  logic [15:0] tmp_frac [0:3];

  wire [2:0]  nports   = (port_select_i == 2'h3) ? 3'h4 : 3'h2;
  wire [4:0]  nsteps   = 5'(dummy_cycle_count_i) + 5'({nports, 1'b0});
  wire        in_dummy = stp_reg < 5'(dummy_cycle_count_i);
  wire [4:0]  j        = stp_reg - 5'(dummy_cycle_count_i);
  wire [2:0]  cur_port = in_dummy ? `SEL_EMUL
                                  : port_of(port_select_i, j[2:1]);
  wire        is_real  = ~in_dummy & j[0];
  wire [1:0]  pidx     = 2'(cur_port - 3'h1);
  wire [31:0] ival     = (32'(port_cycle_interval_i) + 32'h1)
                         * PORT_CYC_BASE;
  wire [30:0] tval     = to_tdc(mcnt_reg, 4'h1);
  wire        is_short = mcnt_reg < 32'(`SHORT_CYC);
  wire        open_evt = cap_above
                         && tcnt_reg >= ival + 32'(`OPEN_CYC);

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      tst_reg      <= tdc_seq_pkg::T_IDLE;
      stp_reg      <= 5'h00;
      tcnt_reg     <= 32'h0;
      mcnt_reg     <= 32'h0;
      err_reg      <= 1'b0;
      temp_set_reg <= 1'b0;
      to_t_reg     <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        res_int[i]  <= 16'h0000;
        res_frac[i] <= 16'h0000;
        tmp_int[i]  <= 16'h0000;
        tmp_frac[i] <= 16'h0000;
      end
    end else begin
      temp_set_reg <= 1'b0;
      to_t_reg     <= 1'b0;
      tcnt_reg     <= tcnt_reg + 32'h1;
      case (tst_reg)
        tdc_seq_pkg::T_IDLE: if (start_temp) begin
          tst_reg  <= tdc_seq_pkg::T_CHARGE;
          stp_reg  <= 5'h00;
          tcnt_reg <= 32'h0;
          err_reg  <= 1'b0;
          for (int i = 0; i < 4; i++) begin
            tmp_int[i]  <= res_int[i];
            tmp_frac[i] <= res_frac[i];
          end
        end
        tdc_seq_pkg::T_CHARGE:
          if (tcnt_reg == 32'(`CHARGE_CYC - 1)) begin
            mcnt_reg <= 32'h0;
            if (cap_above)
              tst_reg <= tdc_seq_pkg::T_MEAS;
            else begin
              err_reg <= 1'b1;
              tst_reg <= tdc_seq_pkg::T_DONE;
            end
          end
        tdc_seq_pkg::T_MEAS: begin
          mcnt_reg <= mcnt_reg + 32'h1;
          if (!cap_above) begin
            tst_reg <= tdc_seq_pkg::T_WAIT;
            if (is_real) begin
              tmp_int[pidx]  <= is_short ? `RES_SHORT
                                         : {1'b0, tval[30:16]};
              tmp_frac[pidx] <= is_short ? `RES_SHORT : tval[15:0];
            end
          end else if (open_evt) begin
            tst_reg  <= tdc_seq_pkg::T_WAIT;
            to_t_reg <= 1'b1;
            if (is_real) begin
              tmp_int[pidx]  <= `RES_BAD;
              tmp_frac[pidx] <= `RES_BAD;
            end
          end
        end
        tdc_seq_pkg::T_WAIT:
          if (tcnt_reg >= ival - 32'h1) begin
            if (stp_reg == nsteps - 5'h01)
              tst_reg <= tdc_seq_pkg::T_DONE;
            else begin
              stp_reg  <= stp_reg + 5'h01;
              tcnt_reg <= 32'h0;
              tst_reg  <= tdc_seq_pkg::T_CHARGE;
            end
          end
        tdc_seq_pkg::T_DONE: begin
          for (int i = 0; i < 4; i++) begin
            res_int[i]  <= err_reg ? `RES_BAD : tmp_int[i];
            res_frac[i] <= err_reg ? `RES_BAD : tmp_frac[i];
          end
          temp_set_reg <= 1'b1;
          tst_reg      <= tdc_seq_pkg::T_IDLE;
        end
        default: tst_reg <= tdc_seq_pkg::T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cap_charge_pin_o <= 1'b0;
      port_route_o     <= `SEL_NONE;
    end else begin
      cap_charge_pin_o <= (tst_reg == tdc_seq_pkg::T_CHARGE);
      port_route_o     <= (tst_reg == tdc_seq_pkg::T_IDLE ||
                           tst_reg == tdc_seq_pkg::T_DONE)
                          ? `SEL_NONE : cur_port;
    end
  end

  // Calibration against the 32 kHz clock
  tdc_seq_pkg::cal_state_t cst_reg;
  logic [31:0] ccnt_reg, csum_reg;
  logic [3:0]  cper_reg;
  logic        cal_set_reg, to_c_reg;

  wire [3:0]  nper   = (cal_period_i == 4'h0) ? 4'h1 : cal_period_i;
  wire [31:0] climit = (32'(measure_timeout_sel_i) + 32'h1)
                       * CAL_TO_BASE;
  wire [30:0] cval   = to_tdc(csum_reg + 32'h1, nper);
  wire        c_over = ~c32_rise && ccnt_reg >= climit;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cst_reg      <= tdc_seq_pkg::C_IDLE;
      ccnt_reg     <= 32'h0;
      csum_reg     <= 32'h0;
      cper_reg     <= 4'h0;
      cal_set_reg  <= 1'b0;
      to_c_reg     <= 1'b0;
      cal_int_reg  <= 16'h0000;
      cal_frac_reg <= 16'h0000;
    end else begin
      cal_set_reg <= 1'b0;
      to_c_reg    <= 1'b0;
      ccnt_reg    <= ccnt_reg + 32'h1;
      case (cst_reg)
        tdc_seq_pkg::C_IDLE: if (start_cal) begin
          cst_reg  <= tdc_seq_pkg::C_SYNC;
          ccnt_reg <= 32'h0;
          csum_reg <= 32'h0;
          cper_reg <= 4'h0;
        end
        tdc_seq_pkg::C_SYNC:
          if (c32_rise) begin
            cst_reg  <= tdc_seq_pkg::C_RUN;
            ccnt_reg <= 32'h0;
          end else if (c_over) begin
            to_c_reg <= 1'b1;
            cst_reg  <= tdc_seq_pkg::C_IDLE;
          end
        tdc_seq_pkg::C_RUN: begin
          csum_reg <= csum_reg + 32'h1;
          if (c32_rise) begin
            ccnt_reg <= 32'h0;
            cper_reg <= cper_reg + 4'h1;
            if (cper_reg == nper - 4'h1) begin
              cal_int_reg  <= {1'b0, cval[30:16]};
              cal_frac_reg <= cval[15:0];
              cal_set_reg  <= 1'b1;
              cst_reg      <= tdc_seq_pkg::C_IDLE;
            end
          end else if (c_over) begin
            to_c_reg <= 1'b1;
            cst_reg  <= tdc_seq_pkg::C_IDLE;
          end
        end
        default: cst_reg <= tdc_seq_pkg::C_IDLE;
      endcase
    end
  end

  // Interrupt status; a set in the clearing cycle wins
  wire [`ST_W-1:0] set_v = {to_t_reg | to_c_reg, cal_set_reg,
                            temp_set_reg};
  wire [`ST_W-1:0] clr_v = (load && ld_addr == `RD_STAT)
                           ? stat_reg : {`ST_W{1'b0}};
  wire [`ST_W-1:0] stat_next = (stat_reg & ~clr_v) | set_v;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      stat_reg <= {`ST_W{1'b0}};
      int_n_o  <= 1'b1;
    end else begin
      stat_reg <= stat_next;
      int_n_o  <= ~(int_enable_i & (|stat_next));
    end
  end
  assign int_status_o = stat_reg;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  sequence s_open;
    tst_reg == tdc_seq_pkg::T_MEAS && open_evt;
  endsequence
  // Covers a missing first edge as well as a long period
  sequence s_cal_err;
    cst_reg != tdc_seq_pkg::C_IDLE && c_over;
  endsequence
  sequence s_cal_end;
    cst_reg == tdc_seq_pkg::C_RUN && c32_rise && cper_reg == nper - 4'h1;
  endsequence

  AST_OPEN_FLAG: assert property (s_open
    |=> to_t_reg ##1 stat_reg[`ST_TO])
    else $error("open probe did not raise timeout");
  AST_TEMP_DONE: assert property (tst_reg == tdc_seq_pkg::T_DONE
    |=> temp_set_reg ##1 stat_reg[`ST_TEMP])
    else $error("temperature done flag missing");
  AST_CAL_KEEP: assert property (s_cal_err
    |=> $stable(cal_int_reg) && $stable(cal_frac_reg) && to_c_reg)
    else $error("calibration result changed on error");
  AST_CAL_DONE: assert property (s_cal_end
    |=> cal_set_reg ##1 stat_reg[`ST_CAL])
    else $error("calibration done flag missing");
  AST_SET_WINS: assert property (|set_v
    |=> (stat_reg & $past(set_v)) == $past(set_v))
    else $error("status event lost");
  AST_INT_PIN: assert property (int_enable_i && |stat_next |=> !int_n_o)
    else $error("interrupt not asserted");
  AST_INT_EN: assert property (!int_enable_i |=> int_n_o)
    else $error("interrupt asserted while disabled");
  AST_DUMMY: assert property (tst_reg == tdc_seq_pkg::T_MEAS && in_dummy
    |-> port_route_o == `SEL_EMUL)
    else $error("dummy cycle not on emulation path");
  AST_DOUT: assert property (sck_rise && rd_mode_reg && !load
    |=> dout_o == $past(tx_reg[15]) && tx_reg[0] == 1'b0)
    else $error("read data not shifted on rising edge");
  AST_BITCNT: assert property (ce_fall |=> bitcnt_reg == 4'h0)
    else $error("bit counter not restarted");
  AST_SAMPLE: assert property (sck_fall && bitcnt_reg < `OP_BITS
    |=> shin_reg[0] == $past(din))
    else $error("input bit not sampled on falling edge");
  AST_START: assert property (start_temp && tst_reg == tdc_seq_pkg::T_IDLE
    |=> tst_reg == tdc_seq_pkg::T_CHARGE ##1 cap_charge_pin_o)
    else $error("temperature command did not start");
endmodule

// ===== verif/host_spi_master.sv
`timescale 1ns/1ps
module host_spi_master (
  input  wire logic clk_i,
  input  wire logic dout_i,
  output logic      ce_n_o,
  output logic      sck_o,
  output logic      din_o
);
  logic        busy = 1'b0;
  logic [15:0] words [0:9];

  initial begin
    ce_n_o = 1'b1;
    sck_o  = 1'b0;
    din_o  = 1'b0;
  end

  // Idle data line toggles so a stale level never passes for a bit
  always @(posedge clk_i) begin
    if (!busy) begin
      din_o <= ~din_o;
    end
  end

  // One 80 ns bit: 8 cycles high, fall samples, 8 cycles low
  task automatic bit_cycle(input logic b, output logic r);
    @(posedge clk_i);
    sck_o <= 1'b1;
    din_o <= b;
    repeat (7) @(posedge clk_i);
    @(negedge clk_i);
    r = dout_i;
    @(posedge clk_i);
    sck_o <= 1'b0;
    repeat (7) @(posedge clk_i);
  endtask

  // Opcode of nbits (normally 8), then nw read words
  task automatic xfer(input logic [7:0] op, input int nbits, input int nw);
    logic r;
    int   i;
    int   k;
    busy = 1'b1;
    @(posedge clk_i);
    ce_n_o <= 1'b0;
    repeat (7) @(posedge clk_i);
    for (i = 0; i < nbits; i++) begin
      bit_cycle(op[7-i], r);
    end
    for (k = 0; k < nw; k++) begin
      for (i = 15; i >= 0; i--) begin
        bit_cycle(1'b0, r);
        words[k][i] = r;
      end
    end
    @(posedge clk_i);
    ce_n_o <= 1'b1;
    repeat (7) @(posedge clk_i);
    busy = 1'b0;
  endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys_i             = 1'b0;
  logic        reset_i               = 1'b1;
  logic        clk_32k_i             = 1'b0;
  logic        run_32k               = 1'b0;
  logic        cap_above_i           = 1'b0;
  logic        sensor_alive          = 1'b1;
  logic [1:0]  port_select_i         = 2'h0;
  logic [2:0]  dummy_cycle_count_i   = 3'h0;
  logic [1:0]  port_cycle_interval_i = 2'h0;
  logic [3:0]  cal_period_i          = 4'h1;
  logic [2:0]  measure_timeout_sel_i = 3'h0;
  logic        int_enable_i          = 1'b0;
  logic        ce_n;
  logic        sck;
  logic        din;
  logic        dout_o;
  logic        cap_charge_pin_o;
  logic [2:0]  port_route_o;
  logic [2:0]  int_status_o;
  logic        int_n_o;
  logic        charge_d              = 1'b0;
  logic [2:0]  meas_route            = 3'h0;
  logic [15:0] cal_frac;
  int          cap_cnt               = 0;
  int          cyc                   = 0;
  int          errors                = 0;
  int          samples_checked       = 0;
  int          rise_at[$];
  logic [2:0]  route_seen[$];
  logic [2:0]  exp_route [0:8] = '{3'h5, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3,
                                   3'h3, 3'h4, 3'h4};

  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  always #15259 if (run_32k) clk_32k_i = ~clk_32k_i;

  // Sensor: T2 shorted, T4 open, others about 8.9 us
  function automatic int hold_cycles(input logic [2:0] route);
    case (route)
      3'h2:    return 800;
      3'h4:    return -1;
      default: return 1780;
    endcase
  endfunction

  always @(posedge clk_sys_i) begin
    cyc      <= cyc + 1;
    charge_d <= cap_charge_pin_o;
    if (cap_charge_pin_o && !charge_d) begin
      rise_at.push_back(cyc);
      route_seen.push_back(port_route_o);
    end
    if (cap_charge_pin_o) begin
      cap_above_i <= sensor_alive;
      cap_cnt     <= 0;
      meas_route  <= port_route_o;
    end else if (cap_above_i) begin
      cap_cnt <= cap_cnt + 1;
      if (cap_cnt == hold_cycles(meas_route)) begin
        cap_above_i <= 1'b0;
      end
    end
  end

  tdc_temp_cal_irq_sequencer #(
    .PORT_CYC_BASE(5000),
    .CAL_TO_BASE  (8000)
  ) DUT (
    .clk_sys_i            (clk_sys_i),
    .reset_i              (reset_i),
    .ce_n_i               (ce_n),
    .sck_i                (sck),
    .din_i                (din),
    .dout_o               (dout_o),
    .clk_32k_i            (clk_32k_i),
    .cap_above_i          (cap_above_i),
    .cap_charge_pin_o     (cap_charge_pin_o),
    .port_route_o         (port_route_o),
    .port_select_i        (port_select_i),
    .dummy_cycle_count_i  (dummy_cycle_count_i),
    .port_cycle_interval_i(port_cycle_interval_i),
    .cal_period_i         (cal_period_i),
    .measure_timeout_sel_i(measure_timeout_sel_i),
    .int_enable_i         (int_enable_i),
    .int_status_o         (int_status_o),
    .int_n_o              (int_n_o)
  );

  host_spi_master HOST (
    .clk_i (clk_sys_i),
    .dout_i(dout_o),
    .ce_n_o(ce_n),
    .sck_o (sck),
    .din_o (din)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_bit(input int b, input int lim);
    int n;
    n = 0;
    while (int_status_o[b] !== 1'b1 && n < lim) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= lim) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, int_status_o, 3'h1 << b);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    // Tests need about 80k cycles; stop at 96k
    #480000;
    errors++;
    stop_test;
  end

  initial begin
    int i;
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    HOST.xfer(8'hFE, 8, 1);
    chk(HOST.words[0], 16'h0000);
    chk(int_n_o, 1'b1);
    HOST.xfer(8'h03, 7, 0);
    repeat (200) @(posedge clk_sys_i);
    chk(route_seen.size(), 0);
    $display("test idle_and_short_opcode done");

    port_select_i       <= 2'h3;
    dummy_cycle_count_i <= 3'h1;
    HOST.xfer(8'h03, 8, 0);
    wait_bit(0, 60000);
    repeat (3) @(posedge clk_sys_i);
    chk(route_seen.size(), 9);
    for (i = 0; i < 9; i++) chk(route_seen[i], exp_route[i]);
    for (i = 0; i < 7; i++) chk(rise_at[i+1] - rise_at[i], 5000);
    chk(int_status_o, 3'h5);
    chk(int_n_o, 1'b1);
    int_enable_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk(int_n_o, 1'b0);
    HOST.xfer(8'hE0, 8, 8);
    chk(HOST.words[0], 16'h0023);
    chk(HOST.words[2], 16'h0000);
    chk(HOST.words[3], 16'h0000);
    chk(HOST.words[4], 16'h0023);
    chk(HOST.words[6], 16'hFFFF);
    chk(HOST.words[7], 16'hFFFF);
    chk(int_n_o, 1'b0);
    HOST.xfer(8'hFE, 8, 1);
    chk(HOST.words[0], 16'h0005);
    chk(int_status_o, 3'h0);
    chk(int_n_o, 1'b1);
    $display("test four_port_sequence done");

    sensor_alive        <= 1'b0;
    port_select_i       <= 2'h1;
    dummy_cycle_count_i <= 3'h0;
    route_seen.delete();
    HOST.xfer(8'h03, 8, 0);
    repeat (4000) @(posedge clk_sys_i);
    chk(route_seen[0], 3'h2);
    HOST.xfer(8'hE0, 8, 8);
    for (i = 0; i < 8; i++) chk(HOST.words[i], 16'hFFFF);
    HOST.xfer(8'hFE, 8, 1);
    $display("test dead_sensor done");

    run_32k      <= 1'b1;
    cal_period_i <= 4'h2;
    HOST.xfer(8'h0E, 8, 0);
    wait_bit(1, 30000);
    repeat (3) @(posedge clk_sys_i);
    chk(int_n_o, 1'b0);
    chk(int_status_o[2], 1'b0);
    HOST.xfer(8'hE8, 8, 2);
    chk(HOST.words[0], 16'h007A);
    cal_frac = HOST.words[1];
    HOST.xfer(8'hFE, 8, 1);
    chk(HOST.words[0], 16'h0002);
    $display("test calibration done");

    run_32k <= 1'b0;
    HOST.xfer(8'h0E, 8, 0);
    wait_bit(2, 20000);
    repeat (3) @(posedge clk_sys_i);
    chk(int_n_o, 1'b0);
    chk(int_status_o[1], 1'b0);
    HOST.xfer(8'hE8, 8, 2);
    chk(HOST.words[0], 16'h007A);
    chk(HOST.words[1], cal_frac);
    $display("test calibration_timeout done");
    stop_test;
  end
endmodule
